// ### inc/amd_pkg.sv
// Constants, register map and encodings of the mode and readout control.
// Assumes a single 125 MHz core clock; the serial front end decodes addresses.
package amd_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned SAMPLE_HZ_SLOW = 125;
  localparam int unsigned SAMPLE_HZ_FAST = 250;
  localparam int unsigned DETECT_BW_HZ = 600;
  localparam int unsigned DETECT_SAMPLE_HZ = 2 * DETECT_BW_HZ;
  localparam int unsigned PULSE_STEP_US = 500;
  localparam int unsigned WINDOW_STEP_US = 1000;
  localparam int unsigned TURN_ON_MAX_MS = 20;
  localparam int unsigned SAMPLE_CYC_SLOW = CLK_HZ / SAMPLE_HZ_SLOW;
  localparam int unsigned SAMPLE_CYC_FAST = CLK_HZ / SAMPLE_HZ_FAST;
  localparam int unsigned DETECT_CYC = CLK_HZ / DETECT_SAMPLE_HZ;
  localparam int unsigned PULSE_STEP_CYC = (CLK_HZ / 1_000_000) * PULSE_STEP_US;
  localparam int unsigned WINDOW_STEP_CYC = (CLK_HZ / 1_000_000) * WINDOW_STEP_US;
  localparam int unsigned TURN_ON_MAX_CYC = (CLK_HZ / 1000) * TURN_ON_MAX_MS;
  localparam int unsigned TICK_CW = 24;

  // ==========================================================
  // Register offsets
  localparam logic [5:0] ADDR_X_LO = 6'h00;
  localparam logic [5:0] ADDR_X_HI = 6'h01;
  localparam logic [5:0] ADDR_Y_LO = 6'h02;
  localparam logic [5:0] ADDR_Y_HI = 6'h03;
  localparam logic [5:0] ADDR_Z_LO = 6'h04;
  localparam logic [5:0] ADDR_Z_HI = 6'h05;
  localparam logic [5:0] ADDR_X8 = 6'h06;
  localparam logic [5:0] ADDR_Y8 = 6'h07;
  localparam logic [5:0] ADDR_Z8 = 6'h08;
  localparam logic [5:0] ADDR_STATUS = 6'h09;
  localparam logic [5:0] ADDR_MODE = 6'h16;
  localparam logic [5:0] ADDR_CTRL1 = 6'h18;
  localparam logic [5:0] ADDR_CTRL2 = 6'h19;
  localparam logic [5:0] ADDR_LVL_THR = 6'h1A;

  // ==========================================================
  // Field layouts and reset values
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned RANGE_LSB = 2;
  localparam int unsigned SELF_TEST_BIT = 4;
  localparam int unsigned THREE_WIRE_BIT = 5;
  localparam int unsigned PIN_DIS_BIT = 6;
  localparam logic [7:0] MODE_WR_MASK = 8'h7F;
  localparam int unsigned BW_BIT = 7;
  localparam int unsigned THOPT_BIT = 6;
  localparam int unsigned XDIS_BIT = 3;
  localparam logic [7:0] CTRL2_WR_MASK = 8'h07;
  localparam int unsigned LVL_POL_BIT = 0;
  localparam int unsigned PLS_POL_BIT = 1;
  localparam int unsigned STAT_RDY_BIT = 0;
  localparam int unsigned STAT_OVR_BIT = 1;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [6:0] THR_LEVELS = 7'h7F;

  // ==========================================================
  // Encodings
  typedef enum logic [1:0] {
    MODE_STANDBY = 2'b00,
    MODE_MEASURE = 2'b01,
    MODE_LEVEL = 2'b10,
    MODE_PULSE = 2'b11
  } amd_mode_t;

  typedef enum logic [1:0] {
    RANGE_8G = 2'b00,
    RANGE_2G = 2'b01,
    RANGE_4G = 2'b10,
    RANGE_RSVD = 2'b11
  } amd_range_t;

  localparam logic [1:0] AXIS_X = 2'b00;
  localparam logic [1:0] AXIS_Y = 2'b01;
  localparam logic [1:0] AXIS_Z = 2'b10;

endpackage

// ### core/amd_tick.sv
// Programmable rate divider giving one-cycle enable pulses.
// Assumes the period input is stable while enabled; disable restarts the count.
`timescale 1ns/1ns
module amd_tick
  import amd_pkg::*;
#(
  parameter int unsigned CW = TICK_CW
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic en_i,
  input wire logic [CW-1:0] period_i,
  output logic tick_o
);

  logic [CW-1:0] cnt_r;

  initial begin
    if (CW < 2) begin
      $error("amd_tick: CW too small");
    end
  end

  // ==========================================================
  // Counter
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || !en_i) begin
      cnt_r <= '0;
      tick_o <= 1'b0;
    end else if (cnt_r >= period_i - CW'(1)) begin
      cnt_r <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + CW'(1);
      tick_o <= 1'b0;
    end
  end

endmodule

// ### core/amd_fifo.sv
// Small synchronous FIFO for conversion results.
// Assumes one clock; push when in_ready, pop when out_valid and out_ready.
`timescale 1ns/1ns
module amd_fifo #(
  parameter int unsigned W = 12,
  parameter int unsigned DEPTH = 4
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("amd_fifo: DEPTH must be a power of two, at least 2");
    end
  end

  assign in_ready_o = (count_r != (AW + 1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign out_data_o = mem_r[rd_ptr_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // ==========================================================
  // Storage and pointers
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      count_r <= count_r + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

endmodule

// ### core/amd_ctrl.sv
// Mode decode, g-range gain, sampling sequence and data-ready control.
// Assumes the serial front end presents decoded register strobes on core_clk_i
// and the converter returns one result per start, in the same clock domain.
`timescale 1ns/1ns

// Contract
// R1: Mode field 00 standby, 01 measure, 10 level detect, 11 pulse detect.
// R2: Range 00 is 8g at 16/g, 01 2g at 64/g, 10 4g at 32/g.
// R3: Range changes apply to the next results without visiting standby.
// R4: 8-bit results offer 2g, 4g, 8g; 10-bit results are 8g only.
// R5: Measurement samples at 125 Hz for 62.5 Hz bandwidth, 250 Hz for 125 Hz.
// R6: Measurement converts all three axes continuously with no host trigger.
// R7: Ready pin goes high once X, Y and Z of a set are done.
// R8: Ready condition mirrored as a status bit at address 09.
// R9: Ready pin stays high until any axis output register is read.
// R10: Overrun bit set when new data overwrite unread data.
// R11: Detection outputs inactive in measurement mode.
// R12: Standby takes no samples, registers stay fully accessible.
// R13: Self-test bit at 16 drives the deflection stimulus.
// R14: Each axis can be excluded from detection; all enabled by default.
// R15: Motion (any above) or freefall (all below), absolute or signed compare.
// R16: Pulse timer steps are 0.5 ms, range 0.5 to 127 ms.
// R17: Latency and window timers step in 1 ms, up to 150 and 250 ms.
// R18: Threshold compare resolves 127 levels.
// R19: Detection modes sample for a 600 Hz detection bandwidth.
// R20: Bandwidth bit clear gives 62.5 Hz, set gives 125 Hz.
// R21: Valid output within 20 ms after leaving standby.
// R22: Mode register bit 7 reads zero and ignores writes.
module amd_ctrl
  import amd_pkg::*;
#(
  parameter int unsigned SAMPLE_SLOW = SAMPLE_CYC_SLOW,
  parameter int unsigned SAMPLE_FAST = SAMPLE_CYC_FAST,
  parameter int unsigned SAMPLE_DETECT = DETECT_CYC,
  parameter int unsigned PULSE_STEP = PULSE_STEP_CYC,
  parameter int unsigned WINDOW_STEP = WINDOW_STEP_CYC,
  parameter int unsigned TURN_ON_MAX = TURN_ON_MAX_CYC,
  parameter int unsigned FIFO_DEPTH = 4
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic conv_start_o,
  output logic [1:0] conv_axis_o,
  input wire logic conv_valid_i,
  input wire logic [9:0] conv_data_i,
  output logic conv_ready_o,
  output logic sample_ready_pin_o,
  output logic self_test_on_o,
  output logic [1:0] gain_code_o,
  output logic three_wire_serial_select_o,
  output logic filter_bw_select_o,
  output logic detect_bw_wide_o,
  output logic detect_hit_o,
  output logic pulse_step_o,
  output logic window_step_o,
  output logic [1:0] op_mode_o
);

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_START = 2'b01,
    SEQ_WAIT = 2'b10
  } amd_seq_t;

  // ==========================================================
  // Declarations
  logic [7:0] mode_r;
  logic [7:0] ctrl1_r;
  logic [7:0] ctrl2_r;
  logic [7:0] lvl_thr_r;
  logic [9:0] x_r;
  logic [9:0] y_r;
  logic [9:0] z_r;
  logic [7:0] x8_r;
  logic [7:0] y8_r;
  logic [7:0] z8_r;
  logic rdy_r;
  logic ovr_r;
  amd_seq_t seq_r;
  logic [1:0] axis_r;
  amd_mode_t mode;
  amd_range_t range;
  logic active;
  logic detecting;
  logic [TICK_CW-1:0] sample_period;
  logic sample_tick;
  logic pulse_tick;
  logic window_tick;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [11:0] fifo_out_data;
  logic [1:0] drain_axis;
  logic [9:0] drain_data;
  logic [7:0] drain8;
  logic drain;
  logic set_done;
  logic out_read;
  logic hit_now;

  initial begin
    if (SAMPLE_SLOW > TURN_ON_MAX || SAMPLE_SLOW >= (1 << TICK_CW)) begin
      $error("amd_ctrl: sample period exceeds turn-on limit or counter");
    end
    if (PULSE_STEP < 2 || WINDOW_STEP < 2 || FIFO_DEPTH < 2) begin
      $error("amd_ctrl: step counts or FIFO depth too small");
    end
  end

  // ==========================================================
  // Functions
  // Gain applied at drain so a range change only affects results drained after it, possibly mid-set
  function automatic logic [7:0] scale8(input logic [9:0] raw, input amd_range_t rng);
    logic [9:0] shifted;
    shifted = raw;
    case (rng)
      RANGE_2G: shifted = raw;
      RANGE_4G: shifted = {raw[9], raw[9:1]};
      default: shifted = {raw[9], raw[9], raw[9:2]};
    endcase
    if (shifted[9] && shifted[8:7] != 2'b11) begin
      scale8 = 8'h80;
    end else if (!shifted[9] && shifted[8:7] != 2'b00) begin
      scale8 = 8'h7F;
    end else begin
      scale8 = shifted[7:0];
    end
  endfunction

  // Absolute magnitude saturates to 127 levels
  function automatic logic cmp_axis(input logic [7:0] v, input logic [7:0] thr,
                                    input logic signed_cmp, input logic below);
    logic [6:0] mag;
    logic [6:0] lim;
    mag = v[7] ? ((v == 8'h80) ? THR_LEVELS : 7'(-v)) : v[6:0];
    lim = thr[6:0];
    if (signed_cmp) begin
      cmp_axis = below ? ($signed(v) < $signed(thr)) : ($signed(v) > $signed(thr));
    end else begin
      cmp_axis = below ? (mag < lim) : (mag > lim);
    end
  endfunction

  function automatic logic is_out_addr(input logic [5:0] a);
    is_out_addr = (a <= ADDR_Z8);
  endfunction

  // ==========================================================
  // Mode decode
  assign mode = amd_mode_t'(mode_r[MODE_LSB +: 2]); // [R1]
  assign range = amd_range_t'(mode_r[RANGE_LSB +: 2]);
  assign active = (mode != MODE_STANDBY); // [R12]
  assign detecting = (mode == MODE_LEVEL) || (mode == MODE_PULSE);

  always_comb begin
    case (mode)
      MODE_MEASURE: begin
        sample_period = ctrl1_r[BW_BIT] ? TICK_CW'(SAMPLE_FAST) : TICK_CW'(SAMPLE_SLOW); // [R5] [R20]
      end
      MODE_LEVEL, MODE_PULSE: begin
        sample_period = TICK_CW'(SAMPLE_DETECT); // [R19]
      end
      default: begin
        sample_period = TICK_CW'(SAMPLE_SLOW);
      end
    endcase
  end

  // ==========================================================
  // Rate dividers
  // Restart on activation puts the first set one period out, under 20 ms
  amd_tick #(.CW(TICK_CW)) u_sample_tick (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .en_i(active), // [R21]
    .period_i(sample_period),
    .tick_o(sample_tick)
  );

  amd_tick #(.CW(TICK_CW)) u_pulse_tick (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .en_i(mode == MODE_PULSE),
    .period_i(TICK_CW'(PULSE_STEP)), // [R16]
    .tick_o(pulse_tick)
  );

  amd_tick #(.CW(TICK_CW)) u_window_tick (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .en_i(mode == MODE_PULSE),
    .period_i(TICK_CW'(WINDOW_STEP)), // [R17]
    .tick_o(window_tick)
  );

  // ==========================================================
  // Register writes
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mode_r <= REG_RESET;
      ctrl1_r <= REG_RESET; // [R14]
      ctrl2_r <= REG_RESET;
      lvl_thr_r <= REG_RESET;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_MODE: mode_r <= reg_wdata_i & MODE_WR_MASK; // [R22] [R3]
        ADDR_CTRL1: ctrl1_r <= reg_wdata_i;
        ADDR_CTRL2: ctrl2_r <= reg_wdata_i & CTRL2_WR_MASK;
        ADDR_LVL_THR: lvl_thr_r <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Conversion sequencer
  // One conversion in flight, started only with FIFO room for its result
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      seq_r <= SEQ_IDLE;
      axis_r <= AXIS_X;
      conv_start_o <= 1'b0;
    end else begin
      conv_start_o <= 1'b0;
      case (seq_r)
        SEQ_IDLE: begin
          axis_r <= AXIS_X;
          if (sample_tick && active) begin
            seq_r <= SEQ_START; // [R6]
          end
        end
        SEQ_START: begin
          if (!active) begin
            seq_r <= SEQ_IDLE; // [R12]
          end else if (fifo_in_ready) begin
            conv_start_o <= 1'b1;
            seq_r <= SEQ_WAIT;
          end
        end
        SEQ_WAIT: begin
          if (conv_valid_i) begin
            if (axis_r == AXIS_Z) begin
              seq_r <= SEQ_IDLE;
            end else begin
              axis_r <= axis_r + 2'd1;
              seq_r <= SEQ_START;
            end
          end
        end
        default: seq_r <= SEQ_IDLE;
      endcase
    end
  end

  assign conv_axis_o = axis_r;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      conv_ready_o <= 1'b0;
    end else begin
      conv_ready_o <= (seq_r == SEQ_WAIT);
    end
  end

  // ==========================================================
  // Result buffer
  // Draining pauses during an output read so no set completes in a read cycle
  assign fifo_out_ready = !(reg_rd_i && is_out_addr(reg_addr_i));

  amd_fifo #(.W(12), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(conv_valid_i && seq_r == SEQ_WAIT),
    .in_ready_o(fifo_in_ready),
    .in_data_i({axis_r, conv_data_i}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  assign drain = fifo_out_valid && fifo_out_ready;
  assign drain_axis = fifo_out_data[11:10];
  assign drain_data = fifo_out_data[9:0];
  assign drain8 = scale8(drain_data, range); // [R2] [R4]
  assign set_done = drain && (drain_axis == AXIS_Z);
  assign out_read = reg_rd_i && is_out_addr(reg_addr_i);

  // ==========================================================
  // Output data
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      x_r <= '0;
      y_r <= '0;
      z_r <= '0;
      x8_r <= '0;
      y8_r <= '0;
      z8_r <= '0;
    end else if (drain) begin
      case (drain_axis)
        AXIS_X: begin
          x_r <= drain_data; // [R4]
          x8_r <= drain8;
        end
        AXIS_Y: begin
          y_r <= drain_data;
          y8_r <= drain8;
        end
        default: begin
          z_r <= drain_data;
          z8_r <= drain8;
        end
      endcase
    end
  end

  // ==========================================================
  // Ready and overrun flags
  // New set wins over a read in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rdy_r <= 1'b0;
      ovr_r <= 1'b0;
    end else begin
      if (set_done) begin
        rdy_r <= 1'b1; // [R7]
      end else if (out_read) begin
        rdy_r <= 1'b0; // [R9]
      end
      if (set_done && rdy_r) begin
        ovr_r <= 1'b1; // [R10]
      end else if (out_read) begin
        ovr_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sample_ready_pin_o <= 1'b0;
    end else begin
      sample_ready_pin_o <= (set_done || (rdy_r && !out_read)) && !mode_r[PIN_DIS_BIT]; // [R7] [R9]
    end
  end

  // ==========================================================
  // Detection compare
  // Disabled axes drop out of the OR and pass in the AND
  always_comb begin
    logic below;
    logic [2:0] en;
    logic [2:0] res;
    below = (mode == MODE_PULSE) ? ctrl2_r[PLS_POL_BIT] : ctrl2_r[LVL_POL_BIT];
    en = ~ctrl1_r[XDIS_BIT +: 3]; // [R14]
    res[0] = cmp_axis(x8_r, lvl_thr_r, ctrl1_r[THOPT_BIT], below); // [R18]
    res[1] = cmp_axis(y8_r, lvl_thr_r, ctrl1_r[THOPT_BIT], below);
    res[2] = cmp_axis(drain8, lvl_thr_r, ctrl1_r[THOPT_BIT], below);
    if (below) begin
      hit_now = (en != 3'b000) && ((res | ~en) == 3'b111); // [R15]
    end else begin
      hit_now = |(res & en); // [R15]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      detect_hit_o <= 1'b0;
    end else if (!detecting) begin
      detect_hit_o <= 1'b0; // [R11]
    end else if (set_done) begin
      detect_hit_o <= hit_now;
    end
  end

  // ==========================================================
  // Control outputs
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      self_test_on_o <= 1'b0;
      gain_code_o <= RANGE_8G;
      three_wire_serial_select_o <= 1'b0;
      filter_bw_select_o <= 1'b0;
      detect_bw_wide_o <= 1'b0;
      pulse_step_o <= 1'b0;
      window_step_o <= 1'b0;
      op_mode_o <= MODE_STANDBY;
    end else begin
      self_test_on_o <= mode_r[SELF_TEST_BIT]; // [R13]
      gain_code_o <= mode_r[RANGE_LSB +: 2]; // [R2] [R3]
      three_wire_serial_select_o <= mode_r[THREE_WIRE_BIT];
      filter_bw_select_o <= ctrl1_r[BW_BIT]; // [R20]
      detect_bw_wide_o <= detecting; // [R19]
      pulse_step_o <= pulse_tick; // [R16]
      window_step_o <= window_tick; // [R17]
      op_mode_o <= mode; // [R1]
    end
  end

  // ==========================================================
  // Register reads
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= '0;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i; // [R12]
      if (reg_rd_i) begin
        case (reg_addr_i)
          ADDR_X_LO: reg_rdata_o <= x_r[7:0];
          ADDR_X_HI: reg_rdata_o <= {{6{x_r[9]}}, x_r[9:8]};
          ADDR_Y_LO: reg_rdata_o <= y_r[7:0];
          ADDR_Y_HI: reg_rdata_o <= {{6{y_r[9]}}, y_r[9:8]};
          ADDR_Z_LO: reg_rdata_o <= z_r[7:0];
          ADDR_Z_HI: reg_rdata_o <= {{6{z_r[9]}}, z_r[9:8]};
          ADDR_X8: reg_rdata_o <= x8_r;
          ADDR_Y8: reg_rdata_o <= y8_r;
          ADDR_Z8: reg_rdata_o <= z8_r;
          ADDR_STATUS: begin
            reg_rdata_o <= '0;
            reg_rdata_o[STAT_RDY_BIT] <= rdy_r; // [R8]
            reg_rdata_o[STAT_OVR_BIT] <= ovr_r; // [R10]
          end
          ADDR_MODE: reg_rdata_o <= mode_r; // [R22]
          ADDR_CTRL1: reg_rdata_o <= ctrl1_r;
          ADDR_CTRL2: reg_rdata_o <= ctrl2_r;
          ADDR_LVL_THR: reg_rdata_o <= lvl_thr_r;
          default: reg_rdata_o <= '0;
        endcase
      end
    end
  end

endmodule

// ### verification/amd_monitor.sv
// Port checks for the mode and readout control.
// Assumes binding to amd_ctrl; sample periods are handed over from it.
`timescale 1ns/1ns
module amd_monitor
  import amd_pkg::*;
#(
  parameter int unsigned SAMPLE_SLOW = 200,
  parameter int unsigned SAMPLE_FAST = 100
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rvalid_o,
  input wire logic conv_start_o,
  input wire logic [1:0] conv_axis_o,
  input wire logic conv_valid_i,
  input wire logic sample_ready_pin_o,
  input wire logic self_test_on_o,
  input wire logic [1:0] gain_code_o,
  input wire logic filter_bw_select_o,
  input wire logic detect_bw_wide_o,
  input wire logic detect_hit_o,
  input wire logic [1:0] op_mode_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ========
  // Spacing of X starts; any write restarts it, the period may change
  logic [15:0] gap_r;
  logic seen_r;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || reg_wr_i || op_mode_o != MODE_MEASURE) begin
      seen_r <= 1'b0;
      gap_r <= 16'h0000;
    end else if (conv_start_o && conv_axis_o == AXIS_X) begin
      seen_r <= 1'b1;
      gap_r <= 16'h0001;
    end else begin
      gap_r <= gap_r + 16'h0001;
    end
  end
  // ========
  // Assertions
  a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o) else $error("no answer");
  a_mode_write: assert property (reg_wr_i && reg_addr_i == ADDR_MODE ##1 !reg_wr_i
    |=> op_mode_o == $past(reg_wdata_i[1:0], 2) && gain_code_o == $past(reg_wdata_i[3:2], 2)
    && self_test_on_o == $past(reg_wdata_i[4], 2)) else $error("mode write not applied");
  a_standby_idle: assert property ((op_mode_o == MODE_STANDBY)[*4] |-> !conv_start_o)
    else $error("start in standby");
  a_measure_quiet: assert property (op_mode_o == MODE_MEASURE
    && $past(op_mode_o) == MODE_MEASURE |-> !detect_hit_o) else $error("hit in measure");
  a_detect_bw: assert property ($stable(op_mode_o) |-> detect_bw_wide_o == op_mode_o[1])
    else $error("detect bandwidth wrong");
  a_pin_clear: assert property (sample_ready_pin_o && reg_rd_i && reg_addr_i <= ADDR_Z8
    && !conv_valid_i && !$past(conv_valid_i) && !$past(conv_valid_i, 2) |=> !sample_ready_pin_o)
    else $error("pin not released");
  a_start_pulse: assert property (conv_start_o |=> !conv_start_o) else $error("long start");
  a_axis_next: assert property (conv_valid_i && conv_axis_o == AXIS_X && op_mode_o == MODE_MEASURE
    |-> ##[2:20] (conv_start_o && conv_axis_o == AXIS_Y) || op_mode_o == MODE_STANDBY)
    else $error("Y not started");
  a_sample_gap: assert property (conv_start_o && conv_axis_o == AXIS_X && seen_r
    |-> gap_r == (filter_bw_select_o ? 16'(SAMPLE_FAST) : 16'(SAMPLE_SLOW)))
    else $error("sample spacing wrong");
  c_ready: cover property ($rose(sample_ready_pin_o));
  c_hit: cover property ($rose(detect_hit_o));
  c_z_start: cover property (conv_start_o && conv_axis_o == AXIS_Z);
endmodule

// ### verification/amd_conv_model.sv
// Converter model: one result per start, fixed value per axis.
// Assumes starts arrive one at a time on the core clock.
`timescale 1ns/1ns
module amd_conv_model (
  input wire logic core_clk_i,
  input wire logic conv_start_i,
  input wire logic [1:0] conv_axis_i,
  output logic conv_valid_o,
  output logic [9:0] conv_data_o
);
  // X +100, Y -200, Z +8; delay grows with axis, prompt to slow
  logic [2:0] dly_r = 3'h0;
  logic [1:0] ax_r = 2'h0;
  initial conv_valid_o = 1'b0;
  initial conv_data_o = 10'h155;
  always @(posedge core_clk_i) begin
    conv_valid_o <= 1'b0;
    conv_data_o <= ~conv_data_o; // Idle data toggles, stale value matches only every other cycle
    if (conv_start_i) begin
      dly_r <= {1'b0, conv_axis_i} + 3'h1;
      ax_r <= conv_axis_i;
    end else if (dly_r == 3'h1) begin
      dly_r <= 3'h0;
      conv_valid_o <= 1'b1;
      conv_data_o <= (ax_r == 2'h0) ? 10'h064 : (ax_r == 2'h1) ? 10'h338 : 10'h008;
    end else if (dly_r != 3'h0) begin
      dly_r <= dly_r - 3'h1;
    end
  end
endmodule

// ### verification/testbench.sv
// Self-checking bench for amd_ctrl with a converter model.
// Assumes shortened sample periods; register port driven at falling edges.
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR %0t value %h expected %h", $time, (a), (b)); end end
module testbench;
  import amd_pkg::*;
  localparam int unsigned SLOW = 200;
  logic core_clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [5:0] reg_addr_i = 6'h00;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
  logic reg_rvalid_o, conv_start_o, conv_valid_i, conv_ready_o, sample_ready_pin_o;
  logic self_test_on_o, three_wire_serial_select_o, filter_bw_select_o, detect_bw_wide_o;
  logic detect_hit_o, pulse_step_o, window_step_o;
  logic [1:0] conv_axis_o, gain_code_o, op_mode_o;
  logic [9:0] conv_data_i;
  logic [1:0] gs [3] = '{2'b01, 2'b10, 2'b00};
  logic [7:0] ye [3] = '{8'h80, 8'h9C, 8'hCE};
  int num_errors = 0, n_checks = 0;
  always #4 core_clk_i = ~core_clk_i;
  amd_ctrl #(.SAMPLE_SLOW(SLOW), .SAMPLE_FAST(100), .SAMPLE_DETECT(40), .PULSE_STEP(20),
    .WINDOW_STEP(40), .TURN_ON_MAX(SLOW)) amd_ctrl_i (.*);
  amd_conv_model amd_conv_model_i (.core_clk_i(core_clk_i), .conv_start_i(conv_start_o),
    .conv_axis_i(conv_axis_o), .conv_valid_o(conv_valid_i), .conv_data_o(conv_data_i));
  // ========
  // Register port tasks
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge core_clk_i);
    reg_wr_i = 1'b0;
  endtask
  task rdc(input logic [5:0] a, input logic [7:0] e);
    @(negedge core_clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge core_clk_i);
    reg_rd_i = 1'b0;
    `CHK(reg_rvalid_o, 1'b1)
    `CHK(reg_rdata_o, e)
  endtask
  task idle(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task results;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wait_pin(input int n);
    for (int i = 0; i < n && sample_ready_pin_o !== 1'b1; i++) @(negedge core_clk_i);
    if (sample_ready_pin_o !== 1'b1) begin
      num_errors++;
      $display("ERROR %0t ready pin stayed low", $time);
      results();
    end
  endtask
  // ========
  // Scenarios
  task t_reset;
    rdc(ADDR_MODE, 8'h00);
    rdc(ADDR_STATUS, 8'h00);
    `CHK(op_mode_o, MODE_STANDBY)
    $display("reset done");
  endtask
  task t_modes;
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_MODE, 8'h84 | 8'(m));
      idle(2);
      `CHK(op_mode_o, 2'(m))
      `CHK(detect_bw_wide_o, m > 1)
    end
    rdc(ADDR_MODE, 8'h07);
    wr(ADDR_MODE, 8'h30);
    idle(2);
    `CHK(self_test_on_o, 1'b1)
    `CHK(three_wire_serial_select_o, 1'b1)
    $display("modes done");
  endtask
  task t_ready;
    wr(ADDR_MODE, 8'h05);
    wait_pin(SLOW + 40);
    rdc(ADDR_STATUS, 8'h01);
    idle(SLOW + 20);
    rdc(ADDR_STATUS, 8'h03);
    rdc(ADDR_X8, 8'h64);
    `CHK(sample_ready_pin_o, 1'b0)
    rdc(ADDR_STATUS, 8'h00);
    $display("ready done");
  endtask
  task t_range;
    for (int g = 0; g < 3; g++) begin
      wr(ADDR_MODE, {4'h0, gs[g], 2'b01});
      wait_pin(SLOW + 40);
      rdc(ADDR_X_LO, 8'h64);
      wait_pin(SLOW + 40);
      rdc(ADDR_X8, 8'h64 >> g);
      rdc(ADDR_Y8, ye[g]);
      rdc(ADDR_Z8, 8'h08 >> g);
    end
    rdc(ADDR_Y_LO, 8'h38);
    rdc(ADDR_Y_HI, 8'hFF);
    rdc(ADDR_X_HI, 8'h00);
    $display("range done");
  endtask
  task t_bw;
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_CTRL1, 8'h80);
    wr(ADDR_MODE, 8'h01);
    `CHK(filter_bw_select_o, 1'b1)
    repeat (3) begin
      wait_pin(SLOW / 2 + 30);
      rdc(ADDR_X8, 8'h19);
    end
    $display("rate done");
  endtask
  task t_detect;
    int np;
    wr(ADDR_LVL_THR, 8'h10);
    wr(ADDR_MODE, 8'h02);
    idle(100);
    `CHK(detect_hit_o, 1'b1)
    wr(ADDR_CTRL1, 8'h18);
    wr(ADDR_CTRL2, 8'h01);
    idle(100);
    `CHK(detect_hit_o, 1'b1)
    wr(ADDR_CTRL2, 8'h00);
    idle(100);
    `CHK(detect_hit_o, 1'b0)
    wr(ADDR_MODE, 8'h03);
    np = 0;
    repeat (400) @(negedge core_clk_i) np += pulse_step_o + 100 * window_step_o;
    `CHK(np, 919)
    wr(ADDR_MODE, 8'h01);
    idle(100);
    `CHK(detect_hit_o, 1'b0)
    $display("detect done");
  endtask
  task t_standby;
    wr(ADDR_MODE, 8'h00);
    idle(20);
    rdc(ADDR_X8, 8'h19);
    idle(SLOW + 20);
    `CHK(sample_ready_pin_o, 1'b0)
    `CHK(conv_ready_o, 1'b0)
    wr(ADDR_LVL_THR, 8'h5A);
    rdc(ADDR_LVL_THR, 8'h5A);
    rdc(6'h3F, 8'h00);
    $display("standby done");
  endtask
  initial begin
    idle(12);
    sys_rst_i = 1'b0;
    t_reset();
    t_modes();
    t_ready();
    t_range();
    t_bw();
    t_detect();
    t_standby();
    results();
  end
endmodule
bind amd_ctrl amd_monitor #(.SAMPLE_SLOW(SAMPLE_SLOW), .SAMPLE_FAST(SAMPLE_FAST)) amd_monitor_i (.*);
